// ---- hw/lpc_frame_div.sv ----
// Frame-rate clock divider running on the link clock
`timescale 1ns/1ps
`default_nettype none
module lpc_frame_div
  import lpc_pkg::*;
(
  input  wire logic                link_clk,
  input  wire logic                link_rst_n,
  input  wire logic                enable,
  input  wire logic [FR_DIV_W-1:0] divider,
  output logic                     fr_clk
);
  logic [FR_DIV_W-1:0] cnt_reg;

  always_ff @(posedge link_clk) begin
    if (!link_rst_n || !enable) begin
      cnt_reg <= '0;
      fr_clk  <= 1'b0;
    end else if (cnt_reg >= divider) begin
      cnt_reg <= '0;
      fr_clk  <= ~fr_clk;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  property p_low_when_off;
    @(posedge link_clk) disable iff (!link_rst_n) !enable |=> !fr_clk;
  endproperty
  a_low_when_off: assert property (p_low_when_off) else $error("frame clock not low");

  property p_toggle_rate;
    @(posedge link_clk) disable iff (!link_rst_n)
      (enable && $stable(divider) && cnt_reg == divider) |=> (fr_clk != $past(fr_clk));
  endproperty
  a_toggle_rate: assert property (p_toggle_rate) else $error("frame clock missed toggle");
endmodule
`default_nettype wire

// ---- hw/lpc_panel_ctrl.sv ----
// Panel control outputs: frame clock, blanking, data enable, power sequencing, user outputs
`timescale 1ns/1ps
`default_nettype none
module lpc_panel_ctrl
  import lpc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        link_clk,
  input  wire lpc_cfg_t    cfg,
  input  wire lpc_timing_t timing,
  input  wire logic        alt_clk_in,
  input  wire logic        suppress_in,
  output logic             panel_frame_rate_clock,
  output logic             video_suppress_n_o,
  output logic             video_suppress_n_oe_n,
  output logic             palette_blank_n,
  output logic             panel_data_valid,
  output logic             bias_inverter_power_n,
  output logic             panel_supply_off,
  output logic             user_output_0,
  output logic             user_output_1
);
  logic           link_rst_s1_reg;
  logic           link_rst_n_reg;
  logic           en_s1_reg;
  logic           en_s2_reg;
  logic           div_req_reg;
  logic           ack_s1_reg;
  logic           ack_s2_reg;
  logic [FR_DIV_W-1:0] div_hold_reg;
  logic           req_s1_reg;
  logic           req_s2_reg;
  logic           div_ack_reg;
  logic [FR_DIV_W-1:0] div_word_reg;
  logic           fr_int;
  logic           sup_s1_reg;
  logic           sup_s2_reg;
  logic           alt_s1_reg;
  logic           alt_s2_reg;
  logic           panel_en;
  logic           supply_on;
  logic [3:0]     step_cnt_reg;
  lpc_pwr_state_t pwr_state_reg;
  lpc_pwr_state_t pwr_state_next;

  assign panel_en  = cfg.panel_config_reg[CFG_PANEL_EN_BIT];
  assign supply_on = cfg.panel_power_ctrl_reg[PWR_SUPPLY_BIT];

  // Link-domain reset, enable and handshake request pass two flops
  always_ff @(posedge link_clk) begin
    link_rst_s1_reg <= rst_n;
    link_rst_n_reg  <= link_rst_s1_reg;
    en_s1_reg       <= cfg.panel_mode;
    en_s2_reg       <= en_s1_reg;
    req_s1_reg      <= div_req_reg;
    req_s2_reg      <= req_s1_reg;
  end

  // Divider word crosses by toggle handshake; held copy stays still while link side loads it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      div_req_reg  <= 1'b0;
      div_hold_reg <= FR_DIV_RST;
    end else if (div_req_reg == ack_s2_reg && cfg.frame_rate_divider_reg != div_hold_reg) begin
      div_req_reg  <= ~div_req_reg;
      div_hold_reg <= cfg.frame_rate_divider_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    ack_s1_reg <= div_ack_reg;
    ack_s2_reg <= ack_s1_reg;
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n_reg) begin
      div_ack_reg  <= 1'b0;
      div_word_reg <= FR_DIV_RST;
    end else if (req_s2_reg != div_ack_reg) begin
      div_ack_reg  <= req_s2_reg;
      div_word_reg <= div_hold_reg;
    end
  end

  lpc_frame_div u_div (
    .link_clk   (link_clk),
    .link_rst_n (link_rst_n_reg),
    .enable     (en_s2_reg),
    .divider    (div_word_reg),
    .fr_clk     (fr_int)
  );

  always_ff @(posedge link_clk) begin
    panel_frame_rate_clock <= fr_int;
  end

  // Pin inputs synchronised
  always_ff @(posedge core_clk) begin
    sup_s1_reg <= suppress_in;
    sup_s2_reg <= sup_s1_reg;
    alt_s1_reg <= alt_clk_in;
    alt_s2_reg <= alt_s1_reg;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      video_suppress_n_o    <= 1'b1;
      video_suppress_n_oe_n <= 1'b1;
      palette_blank_n       <= 1'b1;
    end else if (cfg.aux_video_input_mode) begin
      video_suppress_n_o    <= 1'b1;
      video_suppress_n_oe_n <= 1'b1;
      palette_blank_n       <= sup_s2_reg;
    end else begin
      video_suppress_n_o    <= ~timing.blank_req;
      video_suppress_n_oe_n <= ~cfg.crt_mode;
      palette_blank_n       <= ~timing.blank_req;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      panel_data_valid <= 1'b0;
    end else begin
      panel_data_valid <= cfg.panel_mode & timing.data_valid;
    end
  end

  // Supply first, bias after a settle step; bias goes off in the same cycle as the supply pin drops
  always_comb begin
    pwr_state_next = pwr_state_reg;
    case (pwr_state_reg)
      LPC_PWR_OFF:    if (panel_en && supply_on) pwr_state_next = LPC_PWR_SUPPLY;
      LPC_PWR_SUPPLY: begin
        if (!(panel_en && supply_on)) pwr_state_next = LPC_PWR_DOWN;
        else if (step_cnt_reg == SEQ_STEP_CYC) pwr_state_next = LPC_PWR_ON;
      end
      LPC_PWR_ON:     if (!(panel_en && supply_on)) pwr_state_next = LPC_PWR_DOWN;
      LPC_PWR_DOWN:   if (step_cnt_reg == SEQ_STEP_CYC) pwr_state_next = LPC_PWR_OFF;
      default:        pwr_state_next = LPC_PWR_OFF;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pwr_state_reg <= LPC_PWR_OFF;
      step_cnt_reg  <= 4'h0;
    end else begin
      pwr_state_reg <= pwr_state_next;
      if (pwr_state_next != pwr_state_reg) begin
        step_cnt_reg <= 4'h0;
      end else if (step_cnt_reg != SEQ_STEP_CYC) begin
        step_cnt_reg <= step_cnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bias_inverter_power_n <= 1'b1;
      panel_supply_off      <= 1'b1;
    end else begin
      bias_inverter_power_n <= (pwr_state_next != LPC_PWR_ON);
      // Supply pin follows the bit directly while panel_en is set, else holds; ordering lives in the bias step
      if (panel_en) begin
        panel_supply_off <= ~supply_on;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      user_output_0 <= 1'b0;
      user_output_1 <= 1'b0;
    end else begin
      user_output_0 <= cfg.user_0;
      user_output_1 <= cfg.ext_pclk_mode ? alt_s2_reg : cfg.user_1;
    end
  end

  property p_supply;
    @(posedge core_clk) disable iff (!rst_n)
      panel_en |=> (panel_supply_off == ~$past(supply_on));
  endproperty
  a_supply: assert property (p_supply) else $error("supply pin wrong");

  sequence s_power_up;
    panel_en && supply_on && pwr_state_reg == LPC_PWR_OFF;
  endsequence
  property p_bias_after_supply;
    @(posedge core_clk) disable iff (!rst_n)
      s_power_up |=> bias_inverter_power_n;
  endproperty
  a_bias_after_supply: assert property (p_bias_after_supply) else $error("bias on too early");

  property p_bias_off;
    @(posedge core_clk) disable iff (!rst_n)
      !panel_en |=> bias_inverter_power_n;
  endproperty
  a_bias_off: assert property (p_bias_off) else $error("bias on without panel");

  // Worst case is a restart that must first wait out the power-down step
  sequence s_supply_held;
    (panel_en && supply_on)[*8];
  endsequence
  property p_bias_on_time;
    @(posedge core_clk) disable iff (!rst_n)
      s_supply_held ##1 s_supply_held ##1 (panel_en && supply_on)[*3] |=> !bias_inverter_power_n;
  endproperty
  a_bias_on_time: assert property (p_bias_on_time) else $error("bias never on");

  property p_dv;
    @(posedge core_clk) disable iff (!rst_n)
      panel_data_valid |-> $past(cfg.panel_mode && timing.data_valid);
  endproperty
  a_dv: assert property (p_dv) else $error("data valid spurious");

  property p_aux;
    @(posedge core_clk) disable iff (!rst_n)
      cfg.aux_video_input_mode |=> video_suppress_n_oe_n && palette_blank_n == $past(sup_s2_reg);
  endproperty
  a_aux: assert property (p_aux) else $error("aux input wrong");

  property p_crt;
    @(posedge core_clk) disable iff (!rst_n)
      (cfg.crt_mode && !cfg.aux_video_input_mode)
        |=> !video_suppress_n_oe_n && video_suppress_n_o == !$past(timing.blank_req);
  endproperty
  a_crt: assert property (p_crt) else $error("crt blank wrong");

  property p_user;
    @(posedge core_clk) disable iff (!rst_n)
      !cfg.ext_pclk_mode |=> user_output_0 == $past(cfg.user_0) && user_output_1 == $past(cfg.user_1);
  endproperty
  a_user: assert property (p_user) else $error("user output wrong");

  property p_alt;
    @(posedge core_clk) disable iff (!rst_n)
      cfg.ext_pclk_mode |=> user_output_1 == $past(alt_s2_reg);
  endproperty
  a_alt: assert property (p_alt) else $error("alt clock not routed");
endmodule
`default_nettype wire

// ---- shared/lpc_pkg.sv ----
// Package: constants and carriers for the panel control output block
package lpc_pkg;
  localparam int unsigned FR_DIV_W = 8;
  localparam logic [7:0] FR_DIV_RST = 8'h0F;
  localparam int unsigned CFG_PANEL_EN_BIT = 4;
  localparam int unsigned PWR_SUPPLY_BIT = 2;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] PWR_RST = 8'h00;
  localparam logic [3:0] SEQ_STEP_CYC = 4'h8;

  typedef enum logic [1:0] {
    LPC_PWR_OFF    = 2'b00,
    LPC_PWR_SUPPLY = 2'b01,
    LPC_PWR_ON     = 2'b10,
    LPC_PWR_DOWN   = 2'b11
  } lpc_pwr_state_t;

  typedef struct packed {
    logic       panel_mode;
    logic       crt_mode;
    logic       aux_video_input_mode;
    logic       ext_pclk_mode;
    logic       user_0;
    logic       user_1;
    logic [7:0] frame_rate_divider_reg;
    logic [7:0] panel_power_ctrl_reg;
    logic [7:0] panel_config_reg;
  } lpc_cfg_t;

  typedef struct packed {
    logic blank_req;
    logic data_valid;
  } lpc_timing_t;
endpackage

// ---- testbench/lpc_panel_model.sv ----
// Panel side model: suppress pin level and frame clock period
`timescale 1ns/1ps
`default_nettype none
module lpc_panel_model (
  input  wire logic  supp_o,
  input  wire logic  supp_oe_n,
  input  wire logic  drive_val,
  input  wire logic  fr_clk,
  output logic       pin_level,
  output logic [15:0] fr_period
);
  time last_rise = 0;
  // Panel drives the pin only while the device has let go of it
  assign pin_level = supp_oe_n ? drive_val : supp_o;
  always @(posedge fr_clk) begin
    fr_period = 16'($time - last_rise);
    last_rise = $time;
  end
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the panel control outputs
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import lpc_pkg::*;
  logic        core_clk = 0;
  logic        link_clk = 0;
  logic        rst_n = 0;
  lpc_cfg_t    cfg = '0;
  lpc_timing_t timing = '0;
  logic        alt_clk_in = 0;
  logic        blank_drv = 1;
  logic        pin, fr, s_o, s_oe_n, pal_n, dv, bias_n, s_off, u0, u1;
  logic [15:0] fr_period;
  int          err_count = 0;
  int          n_compared = 0;
  always #2 core_clk = ~core_clk;
  // Odd offset keeps the link edges away from core edges
  initial #7 forever #24 link_clk = ~link_clk;
  lpc_panel_ctrl uut (.core_clk(core_clk), .rst_n(rst_n), .link_clk(link_clk), .cfg(cfg),
    .timing(timing), .alt_clk_in(alt_clk_in), .suppress_in(pin), .panel_frame_rate_clock(fr),
    .video_suppress_n_o(s_o), .video_suppress_n_oe_n(s_oe_n), .palette_blank_n(pal_n),
    .panel_data_valid(dv), .bias_inverter_power_n(bias_n), .panel_supply_off(s_off),
    .user_output_0(u0), .user_output_1(u1));
  lpc_panel_model panel (.supp_o(s_o), .supp_oe_n(s_oe_n), .drive_val(blank_drv), .fr_clk(fr),
    .pin_level(pin), .fr_period(fr_period));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("Compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic t_user();
    cfg.user_0 = 1;
    cfg.user_1 = 1;
    cyc(1);
    check("user", 16'({u0, u1}), 16'h0003);
    cfg.user_0 = 0;
    cfg.ext_pclk_mode = 1;
    cyc(4);
    check("alt_lo", 16'(u1), 16'h0000);
    alt_clk_in = 1;
    cyc(4);
    check("alt_hi", 16'({u0, u1}), 16'h0001);
    cfg.ext_pclk_mode = 0;
    cfg.user_1 = 0;
    cyc(1);
    check("user_off", 16'(u1), 16'h0000);
  endtask
  task automatic t_crt();
    cfg.crt_mode = 1;
    timing.blank_req = 1;
    cyc(2);
    check("crt_blank", 16'({s_o, s_oe_n, pin}), 16'h0000);
    timing.blank_req = 0;
    cyc(1);
    check("crt_disp", 16'(s_o), 16'h0001);
    cfg.aux_video_input_mode = 1;
    blank_drv = 0;
    cyc(4);
    check("aux_blank", 16'({s_oe_n, pal_n}), 16'h0002);
    blank_drv = 1;
    cyc(4);
    check("aux_show", 16'(pal_n), 16'h0001);
    cfg.aux_video_input_mode = 0;
    cfg.crt_mode = 0;
  endtask
  task automatic t_power();
    int n;
    cfg.panel_config_reg[CFG_PANEL_EN_BIT] = 1;
    cfg.panel_power_ctrl_reg[PWR_SUPPLY_BIT] = 1;
    cyc(1);
    check("supply_first", 16'({s_off, bias_n}), 16'h0001);
    n = 1;
    while (bias_n !== 1'h0 && n < 30) begin
      cyc(1);
      n++;
    end
    check("bias_delay", 16'(n), 16'(SEQ_STEP_CYC) + 16'h0002);
    if (n >= 30)
      summarize();
    cyc(12);
    check("bias_hold", 16'(bias_n), 16'h0000);
    cfg.panel_power_ctrl_reg[PWR_SUPPLY_BIT] = 0;
    cyc(1);
    check("power_down", 16'({s_off, bias_n}), 16'h0003);
    cfg.panel_config_reg[CFG_PANEL_EN_BIT] = 0;
    cfg.panel_power_ctrl_reg[PWR_SUPPLY_BIT] = 1;
    cyc(20);
    check("gated", 16'({s_off, bias_n}), 16'h0003);
  endtask
  task automatic t_frame();
    logic [7:0] divs [2] = '{8'h02, 8'h05};
    cfg.panel_mode = 1;
    timing.data_valid = 1;
    cyc(1);
    check("dv_on", 16'(dv), 16'h0001);
    timing.data_valid = 0;
    cyc(1);
    check("dv_off", 16'(dv), 16'h0000);
    foreach (divs[i]) begin
      cfg.frame_rate_divider_reg = divs[i];
      cyc(600);
      check("fr_period", fr_period, 16'(96 * (divs[i] + 1)));
    end
    cfg.panel_mode = 0;
    timing.data_valid = 1;
    cyc(100);
    check("dv_idle", 16'(dv), 16'h0000);
    repeat (100) begin
      cyc(1);
      check("fr_idle", 16'(fr), 16'h0000);
    end
  endtask
  initial begin
    // Long reset so the link side synchroniser also clears
    cyc(60);
    check("reset", 16'({fr, s_o, s_oe_n, pal_n, dv, bias_n, s_off, u0, u1}), 16'h00EC);
    rst_n = 1;
    t_user();
    t_crt();
    t_power();
    t_frame();
    summarize();
  end
endmodule
`default_nettype wire
